//--- core/event_status_query_pkg.sv
// Types shared by the event status query block
package event_status_query_pkg;

    // Which register a query reads
    typedef enum logic [2:0] {
        QUERY_MASK_F = 3'b000,
        QUERY_STD    = 3'b001,
        QUERY_AUX0   = 3'b010,
        QUERY_UNIT1  = 3'b011,
        QUERY_UNIT2  = 3'b100
    } query_sel_t;

endpackage : event_status_query_pkg

//--- core/event_status_query_regs.sv
// Event status registers and their query answers
`timescale 1ns/1ps
`default_nettype none
`include "event_status_query_regs.svh"

module event_status_query_regs #(
    parameter int unsigned MAX_RESP_BYTES = `MAX_RESP_BYTES
) (
    input  wire logic        clock_in,               // 200 MHz
    input  wire logic        rstn_in,                // Async, active low
    input  wire logic        query_valid_in,         // One query per pulse
    input  wire logic [2:0]  query_sel_in,           // Register chosen
    input  wire logic        header_on_in,           // Headers in response
    input  wire logic [11:0] msg_bytes_in,           // Bytes already queued
    input  wire logic        mask_write_in,          // Mask F write strobe
    input  wire logic [7:0]  mask_data_in,           // Mask F write data
    input  wire logic [7:0]  std_event_in,           // Standard event pulses
    input  wire logic [7:0]  aux0_event_in,          // Aux zero event pulses
    input  wire logic        storage_drive_error_in, // Drive fault pulse
    input  wire logic [7:0]  aux0_clear_in,          // Aux zero bit clears
    input  wire logic [6:0]  unit1_range_in,         // First unit over-range
    input  wire logic [6:0]  unit1_chan_read_in,     // First unit channel reads
    input  wire logic [6:0]  unit2_range_in,         // Second unit over-range
    input  wire logic [6:0]  unit2_chan_read_in,     // Second unit channel reads
    output logic             resp_valid_out,         // Answer ready pulse
    output logic [7:0]       resp_value_out,         // Answer value
    output logic [11:0]      resp_bytes_out,         // Answer length in bytes
    output logic             query_error_out         // Oversize refusal pulse
);

    // Stored registers
    logic [7:0]  enable_mask_f_r;            // Mask F contents
    logic [7:0]  standard_event_status_r;    // Standard status
    logic [7:0]  aux_event_status_zero_r;    // Aux register zero
    logic [7:0]  first_unit_range_summary_r; // First unit summary
    logic [7:0]  second_unit_range_summary_r; // Second unit summary

    // Query decode results
    logic [7:0]  sel_value;                  // Value of chosen register
    logic [11:0] sel_header;                 // Header bytes of chosen query
    logic        sel_legal;                  // Select code known
    logic [11:0] resp_len;                   // Length of this response
    logic [12:0] total_len;                  // Message length with it
    logic        too_long;                   // Exceeds the byte limit
    logic        query_ok;                   // Answer will be delivered
    logic        query_bad;                  // Oversize, refused
    logic        std_read_ok;                // Standard status delivered

    // All checks below run on the one clock and sleep during reset
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    // Decimal digit count of a byte value
    function automatic logic [11:0] digit_count(input logic [7:0] value);
        if (value >= 8'h64)
            digit_count = 12'h003;
        else if (value >= 8'h0a)
            digit_count = 12'h002;
        else
            digit_count = 12'h001;
    endfunction : digit_count

    // Register and header for the chosen query
    always_comb
    begin
        sel_value  = 8'h00;
        sel_header = 12'h000;
        sel_legal  = 1'b1;
        unique case (event_status_query_pkg::query_sel_t'(query_sel_in))
            event_status_query_pkg::QUERY_MASK_F:
            begin
                sel_value  = enable_mask_f_r;
                sel_header = `HDR_BYTES_MASK_F;
            end
            event_status_query_pkg::QUERY_STD:
            begin
                sel_value  = standard_event_status_r;
                sel_header = `HDR_BYTES_STD;
            end
            event_status_query_pkg::QUERY_AUX0:
            begin
                sel_value  = aux_event_status_zero_r;
                sel_header = `HDR_BYTES_AUX;
            end
            event_status_query_pkg::QUERY_UNIT1:
            begin
                sel_value  = first_unit_range_summary_r;
                sel_header = `HDR_BYTES_AUX;
            end
            event_status_query_pkg::QUERY_UNIT2:
            begin
                sel_value  = second_unit_range_summary_r;
                sel_header = `HDR_BYTES_AUX;
            end
            // Unknown codes answer nothing and flag a command error
            default:
            begin
                sel_legal = 1'b0;
            end
        endcase
    end

    // length check against the message limit
    always_comb
    begin
        resp_len    = (header_on_in ? sel_header : 12'h000) + digit_count(sel_value);
        total_len   = {1'b0, msg_bytes_in} + {1'b0, resp_len};
        too_long    = (32'(total_len) > MAX_RESP_BYTES);
        query_ok    = query_valid_in && sel_legal && !too_long;
        query_bad   = query_valid_in && sel_legal && too_long;
        std_read_ok = query_ok && (query_sel_in == event_status_query_pkg::QUERY_STD);
    end

    // Answer outputs, one cycle after the query
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            resp_valid_out  <= 1'b0;
            resp_value_out  <= 8'h00;
            resp_bytes_out  <= 12'h000;
            query_error_out <= 1'b0;
        end
        else
        begin
            resp_valid_out  <= query_ok;
            resp_value_out  <= query_ok ? sel_value : 8'h00;
            resp_bytes_out  <= query_ok ? resp_len : 12'h000;
            query_error_out <= query_bad;
        end
    end

    // Mask F holds the last write
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            enable_mask_f_r <= `REG_RESET_VALUE;
        else if (mask_write_in)
            enable_mask_f_r <= mask_data_in;
    end

    // Standard status: events win over the read clear
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            standard_event_status_r <= `REG_RESET_VALUE;
        else
        begin
            // events land at their fixed positions
            standard_event_status_r <= (std_read_ok ? 8'h00 : standard_event_status_r)
                | std_event_in
                | (8'(query_bad) << `STD_QUERY_ERROR_BIT)
                | (8'(query_valid_in && !sel_legal) << `STD_COMMAND_ERROR_BIT);
        end
    end

    // Aux zero: sticky flags, cleared only by explicit strobes
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            aux_event_status_zero_r <= `REG_RESET_VALUE;
        else
        begin
            aux_event_status_zero_r <= ((aux_event_status_zero_r & ~aux0_clear_in)
                | aux0_event_in
                | (8'(storage_drive_error_in) << `AUX0_DRIVE_ERROR_BIT)) & `AUX0_USED_MASK;
        end
    end

    // First unit summary; own query never clears it
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            first_unit_range_summary_r <= `REG_RESET_VALUE;
        else
        begin
            // channel bits 1-6, extra flag bit 0
            // cleared only by the channel read
            first_unit_range_summary_r <= ((first_unit_range_summary_r & ~{1'b0, unit1_chan_read_in})
                | {1'b0, unit1_range_in}) & `UNIT1_USED_MASK;
        end
    end

    // Second unit summary; own query never clears it
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            second_unit_range_summary_r <= `REG_RESET_VALUE;
        else
        begin
            // cleared only by the channel read
            second_unit_range_summary_r <= ((second_unit_range_summary_r & ~{1'b0, unit2_chan_read_in})
                | {1'b0, unit2_range_in}) & `UNIT2_USED_MASK;
        end
    end

    // Checks on the register behaviour

    mask_f_answer_a: assert property (
        query_ok && query_sel_in == 3'b000 |=> resp_valid_out && resp_value_out == $past(enable_mask_f_r))
        else $error("mask F answer differs from stored mask");

    oversize_refused_a: assert property (
        query_bad |=> query_error_out && !resp_valid_out ##0 standard_event_status_r[2])
        else $error("oversize query not refused");

    std_read_clears_a: assert property (
        std_read_ok && std_event_in == 8'h00 |=> standard_event_status_r == 8'h00 && resp_valid_out)
        else $error("standard status not cleared after read");

    std_event_place_a: assert property (
        std_event_in[5] |=> standard_event_status_r[5])
        else $error("command error bit not set");

    drive_error_set_a: assert property (
        storage_drive_error_in |=> aux_event_status_zero_r[4] [*1] ##0 !aux_event_status_zero_r[0])
        else $error("drive fault not at bit 4");

    unit1_set_a: assert property (
        unit1_range_in[3] |=> first_unit_range_summary_r[3])
        else $error("first unit channel 3 not flagged");

    unit1_hold_a: assert property (
        unit1_chan_read_in == 7'h00 |=> ($past(first_unit_range_summary_r) & ~first_unit_range_summary_r) == 8'h00)
        else $error("first unit summary lost without channel read");

    unit2_hold_a: assert property (
        unit2_chan_read_in == 7'h00 |=> ($past(second_unit_range_summary_r) & ~second_unit_range_summary_r) == 8'h00)
        else $error("second unit summary lost without channel read");

    unused_bits_a: assert property (
        second_unit_range_summary_r[7] == 1'b0 && second_unit_range_summary_r[0] == 1'b0
        && first_unit_range_summary_r[7] == 1'b0 && aux_event_status_zero_r[0] == 1'b0)
        else $error("unassigned bit set");

endmodule : event_status_query_regs
`default_nettype wire

//--- core/event_status_query_regs.svh
// Field positions, limits and response lengths for the event status query block
// What this block does
// - Mask F query returns last written mask
// - Oversize response raises query error, nothing sent
// - Standard status query returns value, then clears
// - Standard status bit layout, power-on to op-complete
// - Aux register zero returned; bit 0 unused
// - Storage drive error sets aux bit 4
// - First unit summary: channels bits 1-6, extra 0
// - First unit bits clear only via channel read
// - Second unit bits clear only via channel read
`ifndef EVENT_STATUS_QUERY_REGS_SVH
`define EVENT_STATUS_QUERY_REGS_SVH

// Standard event status bit positions
`define STD_POWER_ON_BIT      7
`define STD_USER_REQUEST_BIT  6
`define STD_COMMAND_ERROR_BIT 5
`define STD_EXEC_ERROR_BIT    4
`define STD_DEVICE_ERROR_BIT  3
`define STD_QUERY_ERROR_BIT   2
`define STD_REQ_CONTROL_BIT   1
`define STD_OP_COMPLETE_BIT   0

// Aux register zero: storage drive error position
`define AUX0_DRIVE_ERROR_BIT  4

// Masks of assigned bits
`define AUX0_USED_MASK        8'hfe
`define UNIT1_USED_MASK       8'h7f
`define UNIT2_USED_MASK       8'h7e

// Reset value of every register
`define REG_RESET_VALUE       8'h00

// Longest response message in bytes
`define MAX_RESP_BYTES        2000

// Header lengths including the trailing space
`define HDR_BYTES_MASK_F      12'h006
`define HDR_BYTES_STD         12'h005
`define HDR_BYTES_AUX         12'h006

`endif

//--- dv/query_host.sv
// Remote host model that issues one register query at a time
`timescale 1ns/1ps
`default_nettype none
module query_host (
    input  wire logic        clock_in,        // Shared clock
    input  wire logic        resp_valid_in,   // Answer pulse
    input  wire logic [7:0]  resp_value_in,   // Answer value
    input  wire logic [11:0] resp_bytes_in,   // Answer length
    input  wire logic        query_error_in,  // Refusal pulse
    output logic             query_valid_out, // Query strobe
    output logic [2:0]       query_sel_out,   // Register chosen
    output logic             header_on_out,   // Header wanted
    output logic [11:0]      msg_bytes_out    // Bytes already queued
);
    // Idle host at time zero
    initial
    begin
        query_valid_out = 1'b0;
        query_sel_out   = 3'h0;
        header_on_out   = 1'b0;
        msg_bytes_out   = 12'h000;
    end

    // Answer stands one cycle only, so it is sampled just after the taking edge
    task automatic ask(input logic [2:0] sel, input logic hdr, input logic [11:0] pre,
                       output logic ok, output logic err, output logic [7:0] val, output logic [11:0] len);
        @(posedge clock_in);
        query_valid_out <= 1'b1;
        query_sel_out   <= sel;
        header_on_out   <= hdr;
        msg_bytes_out   <= pre;
        @(posedge clock_in);
        // Released select and byte count flip so stale values are never trusted
        query_valid_out <= 1'b0;
        query_sel_out   <= ~sel;
        msg_bytes_out   <= ~pre;
        #1;
        ok  = resp_valid_in;
        err = query_error_in;
        val = resp_value_in;
        len = resp_bytes_in;
    endtask : ask
endmodule : query_host
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the event status query block
`timescale 1ns/1ps
`default_nettype none
`include "event_status_query_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
`define PULSE(s, v) begin @(posedge clock_in); s <= v; @(posedge clock_in); s <= '0; end
module testbench;
    // Small limit keeps refusal cases short
    localparam int unsigned MAXB = 20;
    localparam logic [2:0] S_MASK = event_status_query_pkg::QUERY_MASK_F;
    localparam logic [2:0] S_STD  = event_status_query_pkg::QUERY_STD;
    localparam logic [2:0] S_AUX  = event_status_query_pkg::QUERY_AUX0;
    localparam logic [2:0] S_U1   = event_status_query_pkg::QUERY_UNIT1;
    localparam logic [2:0] S_U2   = event_status_query_pkg::QUERY_UNIT2;
    logic        clock_in = 1'b0;       // 200 MHz
    logic        rstn_in  = 1'b0;       // Held low at start
    logic        qv, hdr, rv, qe;       // Query port wires
    logic [2:0]  qsel;                  // Query select wire
    logic [11:0] pre, rb;               // Queued and answer bytes
    logic [7:0]  rval;                  // Answer value
    logic        mw = 1'b0, sde = 1'b0; // Mask write, drive fault
    logic [7:0]  md = 8'h00, sev = 8'h00, aev = 8'h00, aclr = 8'h00;
    logic [6:0]  u1 = 7'h00, u1rd = 7'h00, u2 = 7'h00, u2rd = 7'h00;
    int          miscompares = 0;
    int          n_compared = 0;

    always #2.5 clock_in = ~clock_in;

    query_host query_host_i (.clock_in(clock_in), .resp_valid_in(rv), .resp_value_in(rval),
        .resp_bytes_in(rb), .query_error_in(qe), .query_valid_out(qv), .query_sel_out(qsel),
        .header_on_out(hdr), .msg_bytes_out(pre));

    event_status_query_regs #(.MAX_RESP_BYTES(MAXB)) event_status_query_regs_i (
        .clock_in(clock_in), .rstn_in(rstn_in), .query_valid_in(qv), .query_sel_in(qsel),
        .header_on_in(hdr), .msg_bytes_in(pre), .mask_write_in(mw), .mask_data_in(md),
        .std_event_in(sev), .aux0_event_in(aev), .storage_drive_error_in(sde), .aux0_clear_in(aclr),
        .unit1_range_in(u1), .unit1_chan_read_in(u1rd), .unit2_range_in(u2), .unit2_chan_read_in(u2rd),
        .resp_valid_out(rv), .resp_value_out(rval), .resp_bytes_out(rb), .query_error_out(qe));

    // Decimal digit count of an answer
    function automatic logic [11:0] digits(input logic [7:0] v);
        return (v >= 8'h64) ? 12'h003 : ((v >= 8'h0a) ? 12'h002 : 12'h001);
    endfunction : digits

    // One query and its four expected outcomes
    task automatic check(input logic [2:0] s, input logic h, input logic [11:0] p,
                         input logic eok, input logic eerr, input logic [7:0] ev);
        logic        ok, err;
        logic [7:0]  val;
        logic [11:0] len, hb, el;
        hb = (s == S_STD) ? `HDR_BYTES_STD : ((s == S_MASK) ? `HDR_BYTES_MASK_F : `HDR_BYTES_AUX);
        el = eok ? ((h ? hb : 12'h000) + digits(ev)) : 12'h000;
        query_host_i.ask(s, h, p, ok, err, val, len);
        `CHK("valid", eok, ok)
        `CHK("error", eerr, err)
        `CHK("value", eok ? ev : 8'h00, val)
        `CHK("bytes", el, len)
    endtask : check

    // Counts, verdict, end of run
    task automatic wrap_up;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Hang guard counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        check(S_MASK, 1'b1, 12'h000, 1'b1, 1'b0, 8'h00);
        @(posedge clock_in); md <= 8'hff; mw <= 1'b1; @(posedge clock_in); mw <= 1'b0;
        check(S_MASK, 1'b0, 12'h000, 1'b1, 1'b0, 8'hff);
        // Every standard bit at its own place, then cleared by the read
        for (int i = 0; i < 8; i++)
        begin
            `PULSE(sev, 8'h01 << i)
            check(S_STD, 1'b1, 12'h000, 1'b1, 1'b0, 8'h01 << i);
            check(S_STD, 1'b0, 12'h000, 1'b1, 1'b0, 8'h00);
        end
        check(3'h5, 1'b0, 12'h000, 1'b0, 1'b0, 8'h00);
        check(S_STD, 1'b0, 12'h000, 1'b1, 1'b0, 8'h20);
        // Limit boundary: one byte over refused, exactly at the limit served
        `PULSE(sev, 8'h01)
        check(S_STD, 1'b1, 12'h00f, 1'b0, 1'b1, 8'h00);
        check(S_STD, 1'b1, 12'h00e, 1'b1, 1'b0, 8'h05);
        `PULSE(sde, 1'b1)
        check(S_AUX, 1'b1, 12'h000, 1'b1, 1'b0, 8'h10);
        `PULSE(aev, 8'hff)
        check(S_AUX, 1'b0, 12'h000, 1'b1, 1'b0, 8'hfe);
        check(S_AUX, 1'b0, 12'h000, 1'b1, 1'b0, 8'hfe);
        `PULSE(aclr, 8'hff)
        check(S_AUX, 1'b0, 12'h000, 1'b1, 1'b0, 8'h00);
        `PULSE(u1, 7'h7f)
        check(S_U1, 1'b1, 12'h000, 1'b1, 1'b0, 8'h7f);
        check(S_U1, 1'b1, 12'h000, 1'b1, 1'b0, 8'h7f);
        `PULSE(u1rd, 7'h02)
        check(S_U1, 1'b1, 12'h000, 1'b1, 1'b0, 8'h7d);
        `PULSE(u2, 7'h7f)
        check(S_U2, 1'b0, 12'h000, 1'b1, 1'b0, 8'h7e);
        check(S_U2, 1'b0, 12'h000, 1'b1, 1'b0, 8'h7e);
        `PULSE(u2rd, 7'h7e)
        check(S_U2, 1'b0, 12'h000, 1'b1, 1'b0, 8'h00);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
